// >>> logic/codec_ctl_defs.vh
// Constants for the codec control command decoder
`ifndef CODEC_CTL_DEFS_VH
`define CODEC_CTL_DEFS_VH

// Command byte fields
`define CMD_DIR_BIT 7
`define CLS_LOCAL 2'b00
`define CLS_GLOBAL 2'b01
`define CLS_BAD 2'b10
`define CLS_RAM 2'b11
`define RAM_MSG_BIT 4

// Access space codes on the access port
`define SPACE_LOCAL 2'b00
`define SPACE_GLOBAL 2'b01
`define SPACE_COEF 2'b10
`define SPACE_MSG 2'b11

// Identification byte (arbitrary neutral value)
`define ID_BYTE 8'h5A

// Channel select register: global address and enable field
`define CHSEL_ADDR 5'h05
`define CE_MSB 7
`define CE_LSB 4

// Power control registers
`define LPWR_ADDR 5'h08
`define STBY_BIT 0
`define GPWR_ADDR 5'h15
`define PLL_SLEEP_BIT 0
`define STANDBY_RESET 4'hF
`define PLL_SLEEP_RESET 1'b0

// RAM block transfer: 8 words, 2 bytes each
`define RAM_LAST_WORD 3'h7
`define RAM_BYTES 5'h10

`endif

// >>> logic/serial_byte_port.v
// Serial control port: pin synchronisers, byte receive and transmit shifters
`timescale 1ns/10ps
module serial_byte_port (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Pins
    input wire cs_n_pin,
    input wire sclk_pin,
    input wire sdi_pin,
    output wire sdo_out,
    // Byte side
    input wire [7:0] tx_byte,
    input wire tx_load,
    output wire cs_active,
    output reg rx_valid_r,
    output reg [7:0] rx_byte_r
);

reg cs_s1_r;
reg cs_s2_r;
reg ck_s1_r;
reg ck_s2_r;
reg ck_s3_r;
reg di_s1_r;
reg di_s2_r;
reg [6:0] rx_sh_r;
reg [2:0] cnt_r;
reg skip_r;
reg [7:0] tx_sh_r;
wire rise;
wire fall;

assign rise = ck_s2_r & ~ck_s3_r;
assign fall = ~ck_s2_r & ck_s3_r;
assign cs_active = ~cs_s2_r;
assign sdo_out = tx_sh_r[7];

always @(posedge core_clk)
begin
    if (reset)
    begin
        cs_s1_r <= 1'b1;
        cs_s2_r <= 1'b1;
        // Serial clock rests low, so no false edge follows reset
        ck_s1_r <= 1'b0;
        ck_s2_r <= 1'b0;
        ck_s3_r <= 1'b0;
        di_s1_r <= 1'b0;
        di_s2_r <= 1'b0;
        rx_sh_r <= 7'h00;
        cnt_r <= 3'h0;
        skip_r <= 1'b0;
        tx_sh_r <= 8'h00;
        rx_valid_r <= 1'b0;
        rx_byte_r <= 8'h00;
    end
    else
    begin
        cs_s1_r <= cs_n_pin;
        cs_s2_r <= cs_s1_r;
        ck_s1_r <= sclk_pin;
        ck_s2_r <= ck_s1_r;
        ck_s3_r <= ck_s2_r;
        di_s1_r <= sdi_pin;
        di_s2_r <= di_s1_r;
        rx_valid_r <= 1'b0;
        if (!cs_active)
        begin
            // Partial byte is dropped when select rises
            cnt_r <= 3'h0;
            skip_r <= 1'b0;
        end
        else if (rise)
        begin
            rx_sh_r <= {rx_sh_r[5:0], di_s2_r};
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7)
            begin
                rx_valid_r <= 1'b1;
                rx_byte_r <= {rx_sh_r, di_s2_r};
                skip_r <= 1'b1;
            end
        end
        // Fall right after a byte end keeps the next byte's first bit
        if (tx_load)
            tx_sh_r <= tx_byte;
        else if (cs_active && fall)
        begin
            if (skip_r)
                skip_r <= 1'b0;
            else
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end
    end
end

endmodule

// >>> logic/codec_control_command_decoder.v
// Command decoder for the serial control port of a four-channel codec
// Summary of operation
// - Command bit 7: zero read, one write
// - Bits 6..5: local, global, RAM classes
// - Low five bits address local/global register
// - RAM bit 4 picks coefficient or message
// - Enable field bits map channels 4..1
// - Writes go to all enabled channels
// - Reads send identification byte first
// - Register access counts down to low address bits 00
// - Select high aborts, finished accesses kept
// - Standby bit stops that channel only
// - Reset leaves all channels in standby
// - Commands still run during channel standby
// - Suspend when PLL sleep and all standby
// - No RAM operations while suspended
// - Global commands ignore channel enables
// - Coefficient block: eight words, top first
// - Message block: eight words, top first
`timescale 1ns/10ps
`include "codec_ctl_defs.vh"
module codec_control_command_decoder (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Serial control pins
    input wire cs_n_pin,
    input wire sclk_pin,
    input wire sdi_pin,
    output wire sdo_out,
    output wire sdo_oe,
    // Register and RAM access port
    output reg acc_wr_r,
    output reg acc_rd_r,
    output reg [1:0] acc_space_r,
    output reg [4:0] acc_addr_r,
    output reg [2:0] acc_word_r,
    output reg [3:0] acc_mask_r,
    output reg [15:0] acc_wdata_r,
    input wire [15:0] acc_rdata,
    // Channel and power state
    output wire [3:0] channel_enable,
    output wire [3:0] chan_standby,
    output wire pll_sleep,
    output wire suspend
);

localparam ST_IDLE = 2'h0;
localparam ST_WRITE = 2'h1;
localparam ST_READ = 2'h2;
localparam ST_DISCARD = 2'h3;

reg [1:0] state_r;
reg [1:0] space_r;
reg [4:0] addr_r;
reg [4:0] left_r;
reg hi_r;
reg [2:0] word_r;
reg [7:0] hold_r;
reg [15:0] pend_r;
reg cap_r;
reg ram_ok_r;
reg drive_r;
reg [3:0] ce_r;
reg [3:0] standby_r;
reg pll_sleep_r;
reg [7:0] tx_byte_r;
reg tx_load_r;
reg [15:0] rdata_mux;
wire cs_active;
wire rx_valid;
wire [7:0] rx_byte;
wire is_ram;

serial_byte_port u_port (
    .core_clk(core_clk),
    .reset(reset),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .sdi_pin(sdi_pin),
    .sdo_out(sdo_out),
    .tx_byte(tx_byte_r),
    .tx_load(tx_load_r),
    .cs_active(cs_active),
    .rx_valid_r(rx_valid),
    .rx_byte_r(rx_byte)
);

function [4:0] addr_down;
    input [4:0] a;
    begin
        addr_down = {a[4:2], a[1:0] - 2'b01};
    end
endfunction

assign is_ram = space_r[1];
assign sdo_oe = drive_r & cs_active;
assign channel_enable = ce_r;
assign chan_standby = standby_r;
assign pll_sleep = pll_sleep_r;
assign suspend = pll_sleep_r & (&standby_r);

// Read data: channel select and global power registers answer here, the rest (local power included) from outside
always @*
begin
    rdata_mux = acc_rdata;
    if (acc_space_r == `SPACE_GLOBAL && acc_addr_r == `CHSEL_ADDR)
        rdata_mux = {8'h00, ce_r, 4'h0};
    else if (acc_space_r == `SPACE_GLOBAL && acc_addr_r == `GPWR_ADDR)
        rdata_mux = {15'h0000, pll_sleep_r};
end

always @(posedge core_clk)
begin
    if (reset)
    begin
        state_r <= ST_IDLE;
        space_r <= `SPACE_LOCAL;
        addr_r <= 5'h00;
        left_r <= 5'h00;
        hi_r <= 1'b1;
        word_r <= `RAM_LAST_WORD;
        hold_r <= 8'h00;
        pend_r <= 16'h0000;
        cap_r <= 1'b0;
        ram_ok_r <= 1'b0;
        drive_r <= 1'b0;
        ce_r <= 4'h0;
        standby_r <= `STANDBY_RESET;
        pll_sleep_r <= `PLL_SLEEP_RESET;
        tx_byte_r <= 8'h00;
        tx_load_r <= 1'b0;
        acc_wr_r <= 1'b0;
        acc_rd_r <= 1'b0;
        acc_space_r <= `SPACE_LOCAL;
        acc_addr_r <= 5'h00;
        acc_word_r <= 3'h0;
        acc_mask_r <= 4'h0;
        acc_wdata_r <= 16'h0000;
    end
    else
    begin
        acc_wr_r <= 1'b0;
        acc_rd_r <= 1'b0;
        tx_load_r <= 1'b0;
        cap_r <= acc_rd_r;
        if (cap_r)
            pend_r <= rdata_mux;
        if (!cs_active)
        begin
            // Abort: earlier completed accesses stay as they are
            state_r <= ST_IDLE;
            drive_r <= 1'b0;
        end
        else if (rx_valid)
        begin
            case (state_r)
            ST_IDLE:
            begin
                hi_r <= 1'b1;
                word_r <= `RAM_LAST_WORD;
                ram_ok_r <= ~suspend;
                case (rx_byte[6:5])
                `CLS_LOCAL, `CLS_GLOBAL:
                begin
                    space_r <= rx_byte[5] ? `SPACE_GLOBAL : `SPACE_LOCAL;
                    addr_r <= rx_byte[4:0];
                    left_r <= {3'b000, rx_byte[1:0]} + 5'h01;
                end
                `CLS_RAM:
                begin
                    if (rx_byte[`RAM_MSG_BIT])
                    begin
                        space_r <= `SPACE_MSG;
                        addr_r <= {2'b00, rx_byte[2:0]};
                    end
                    else
                    begin
                        space_r <= `SPACE_COEF;
                        addr_r <= {1'b0, rx_byte[3:0]};
                    end
                    left_r <= `RAM_BYTES;
                end
                default:
                    left_r <= 5'h00;
                endcase
                if (rx_byte[6:5] == `CLS_BAD)
                    state_r <= ST_DISCARD;
                else if (rx_byte[`CMD_DIR_BIT])
                    state_r <= ST_WRITE;
                else
                begin
                    state_r <= ST_READ;
                    tx_byte_r <= `ID_BYTE;
                    tx_load_r <= 1'b1;
                    drive_r <= 1'b1;
                    // First item is fetched while the identifier shifts out
                    acc_rd_r <= (rx_byte[6:5] != `CLS_RAM) | ~suspend;
                    acc_word_r <= `RAM_LAST_WORD;
                    if (rx_byte[6:5] == `CLS_RAM)
                    begin
                        acc_space_r <= rx_byte[`RAM_MSG_BIT] ?
                            `SPACE_MSG : `SPACE_COEF;
                        acc_addr_r <= rx_byte[`RAM_MSG_BIT] ?
                            {2'b00, rx_byte[2:0]} : {1'b0, rx_byte[3:0]};
                    end
                    else
                    begin
                        acc_space_r <= rx_byte[5] ?
                            `SPACE_GLOBAL : `SPACE_LOCAL;
                        acc_addr_r <= rx_byte[4:0];
                    end
                    acc_mask_r <= rx_byte[5] ? 4'h0 : ce_r;
                end
            end
            ST_WRITE:
            begin
                left_r <= left_r - 5'h01;
                if (left_r == 5'h01)
                    state_r <= ST_DISCARD;
                acc_space_r <= space_r;
                acc_addr_r <= addr_r;
                acc_mask_r <= (space_r == `SPACE_GLOBAL) ? 4'h0 : ce_r;
                if (!is_ram)
                begin
                    acc_wr_r <= 1'b1;
                    acc_wdata_r <= {8'h00, rx_byte};
                    addr_r <= addr_down(addr_r);
                    if (space_r == `SPACE_GLOBAL && addr_r == `CHSEL_ADDR)
                        ce_r <= rx_byte[`CE_MSB:`CE_LSB];
                    if (space_r == `SPACE_GLOBAL && addr_r == `GPWR_ADDR)
                        pll_sleep_r <= rx_byte[`PLL_SLEEP_BIT];
                    if (space_r == `SPACE_LOCAL && addr_r == `LPWR_ADDR)
                        standby_r <= (standby_r & ~ce_r) |
                            (ce_r & {4{rx_byte[`STBY_BIT]}});
                end
                else if (hi_r)
                begin
                    hold_r <= rx_byte;
                    hi_r <= 1'b0;
                end
                else
                begin
                    acc_wr_r <= ram_ok_r;
                    acc_word_r <= word_r;
                    if (space_r == `SPACE_COEF)
                        acc_wdata_r <= {hold_r, rx_byte[7:2], 2'b00};
                    else
                        acc_wdata_r <= {hold_r, rx_byte};
                    word_r <= word_r - 3'h1;
                    hi_r <= 1'b1;
                end
            end
            ST_READ:
            begin
                tx_load_r <= 1'b1;
                left_r <= left_r - 5'h01;
                if (left_r == 5'h01)
                    state_r <= ST_DISCARD;
                if (!is_ram)
                begin
                    tx_byte_r <= pend_r[7:0];
                    addr_r <= addr_down(addr_r);
                    acc_addr_r <= addr_down(addr_r);
                    acc_rd_r <= (left_r != 5'h01);
                end
                else if (hi_r)
                begin
                    tx_byte_r <= pend_r[15:8];
                    hi_r <= 1'b0;
                end
                else
                begin
                    tx_byte_r <= pend_r[7:0];
                    hi_r <= 1'b1;
                    word_r <= word_r - 3'h1;
                    acc_word_r <= word_r - 3'h1;
                    acc_rd_r <= (left_r != 5'h01) & ram_ok_r;
                end
            end
            default:
            begin
                // Bytes beyond the command are ignored, reads pad zeros
                tx_byte_r <= 8'h00;
                tx_load_r <= drive_r;
            end
            endcase
        end
    end
end

endmodule

// >>> dv/codec_ctl_sva.sv
// Port assertions for the command decoder
`timescale 1ns/10ps
`include "codec_ctl_defs.vh"
module codec_ctl_sva (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Pins and access port
    input wire cs_n_pin,
    input wire sdo_oe,
    input wire acc_wr_r,
    input wire acc_rd_r,
    input wire [1:0] acc_space_r,
    input wire [3:0] acc_mask_r,
    input wire [15:0] acc_wdata_r,
    // Channel and power state
    input wire [3:0] channel_enable,
    input wire [3:0] chan_standby,
    input wire pll_sleep,
    input wire suspend
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_susp_def: assert property (
        suspend == (pll_sleep && &chan_standby))
        else $error("suspend differs from power bits");
    chk_ram_susp: assert property (
        (acc_wr_r || acc_rd_r) && suspend |-> !acc_space_r[1])
        else $error("RAM access while suspended");
    chk_global_mask: assert property (
        acc_wr_r && acc_space_r == `SPACE_GLOBAL |-> acc_mask_r == 4'h0)
        else $error("global write carries channel mask");
    chk_local_mask: assert property (
        acc_wr_r && acc_space_r == `SPACE_LOCAL
        |-> acc_mask_r == channel_enable)
        else $error("local write mask differs from enables");
    chk_wr_spacing: assert property (
        acc_wr_r |=> !acc_wr_r [*8])
        else $error("write pulses too close");
    chk_coef_low: assert property (
        acc_wr_r && acc_space_r == `SPACE_COEF |-> acc_wdata_r[1:0] == 2'h0)
        else $error("coefficient low bits not cleared");
    chk_reset_state: assert property (
        $fell(reset) |-> chan_standby == `STANDBY_RESET
        && pll_sleep == `PLL_SLEEP_RESET)
        else $error("power state wrong after reset");
    chk_cs_idle: assert property (
        cs_n_pin [*5] |-> !sdo_oe)
        else $error("output driven with select high");
    cover property (acc_wr_r && acc_mask_r == 4'h3);
    cover property (acc_rd_r);
    cover property (suspend && acc_wr_r);
endmodule

// >>> dv/ctl_host.sv
// Host model driving the serial control port
`timescale 1ns/10ps
module ctl_host (
    // Clock
    input wire core_clk,
    // Serial pins
    output reg cs_n_pin,
    output reg sclk_pin,
    output reg sdi_pin,
    input wire sdo_out
);
    initial
    begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        sdi_pin = 1'b1;
    end
    task automatic half;
        repeat (6) @(posedge core_clk);
        #1;
    endtask
    // Serial clock rests low between frames
    task automatic open_f;
        @(posedge core_clk);
        #1 cs_n_pin = 1'b0;
        half;
    endtask
    // One byte each way, MSB first, output sampled at rising clock
    task automatic xfer(input [7:0] b, output [7:0] r);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
        begin
            sdi_pin = b[i];
            half;
            sclk_pin = 1'b1;
            r[i] = sdo_out;
            half;
            sclk_pin = 1'b0;
        end
        sdi_pin = ~b[0];
    endtask
    task automatic close_f;
        half;
        cs_n_pin = 1'b1;
        half;
    endtask
endmodule

// >>> dv/tb.sv
// Testbench for the codec control command decoder
`timescale 1ns/10ps
`include "codec_ctl_defs.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
    logic core_clk, reset;
    wire cs_n_pin, sclk_pin, sdi_pin, sdo_out, sdo_oe;
    wire acc_wr_r, acc_rd_r, pll_sleep, suspend;
    wire [1:0] acc_space_r;
    wire [4:0] acc_addr_r;
    wire [2:0] acc_word_r;
    wire [3:0] acc_mask_r, channel_enable, chan_standby;
    wire [15:0] acc_wdata_r, acc_rdata;
    int n_mismatch, num_checks, cyc, n_rd;
    logic [29:0] wq[$];
    logic [7:0] r;
    // Far side answers with its own word index and address
    assign acc_rdata = {8'h3C ^ {5'h00, acc_word_r}, 3'h0, acc_addr_r} ^
        16'h00C0;
    codec_control_command_decoder codec_control_command_decoder_i (
        .core_clk, .reset, .cs_n_pin, .sclk_pin, .sdi_pin, .sdo_out,
        .sdo_oe, .acc_wr_r, .acc_rd_r, .acc_space_r, .acc_addr_r,
        .acc_word_r, .acc_mask_r, .acc_wdata_r, .acc_rdata,
        .channel_enable, .chan_standby, .pll_sleep, .suspend);
    ctl_host ctl_host_i (.core_clk, .cs_n_pin, .sclk_pin, .sdi_pin,
        .sdo_out);
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (acc_rd_r === 1'b1)
            n_rd++;
        if (acc_wr_r === 1'b1)
            wq.push_back({acc_space_r, acc_addr_r,
                acc_space_r[1] ? acc_word_r : 3'h0, acc_mask_r, acc_wdata_r});
        if (cyc == 40000)
        begin
            n_mismatch++;
            conclude;
        end
    end
    function [29:0] wv(input [1:0] s, input [4:0] a, input [2:0] w,
        input [3:0] m, input [15:0] d);
        wv = {s, a, w, m, d};
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic put(input [7:0] b);
        ctl_host_i.xfer(b, r);
    endtask
    task automatic frame2(input [7:0] c, input [7:0] d);
        ctl_host_i.open_f;
        put(c);
        put(d);
        ctl_host_i.close_f;
    endtask
    task automatic setce(input [7:0] d);
        frame2(8'hA5, d);
        wq.delete();
    endtask
    task automatic ram(input [7:0] c, input int n);
        int i;
        ctl_host_i.open_f;
        put(c);
        for (i = 0; i < n; i++)
            put({i[3:0], 4'h7});
        ctl_host_i.close_f;
    endtask
    task automatic expw(input [29:0] e);
        logic [29:0] g;
        g = (wq.size() != 0) ? wq.pop_front() : 30'hX;
        `CHK(g, e)
    endtask
    task automatic t_reset;
        `CHK(chan_standby, `STANDBY_RESET)
        `CHK(pll_sleep, 1'b0)
        `CHK(channel_enable, 4'h0)
        $display("test reset done");
    endtask
    task automatic t_bcast;
        setce(8'h30);
        `CHK(channel_enable, 4'h3)
        ctl_host_i.open_f;
        put(8'h81);
        put(8'h5E);
        put(8'hA7);
        ctl_host_i.close_f;
        expw(wv(`SPACE_LOCAL, 5'h01, 3'h0, 4'h3, 16'h005E));
        expw(wv(`SPACE_LOCAL, 5'h00, 3'h0, 4'h3, 16'h00A7));
        `CHK(wq.size(), 0)
        $display("test broadcast done");
    endtask
    task automatic t_read;
        int a;
        setce(8'h10);
        n_rd = 0;
        ctl_host_i.open_f;
        put(8'h02);
        put(8'hFF);
        `CHK(r, `ID_BYTE)
        `CHK(sdo_oe, 1'b1)
        for (a = 2; a >= 0; a--)
        begin
            put(8'hFF);
            `CHK(r, 8'hC0 | a[7:0])
        end
        ctl_host_i.close_f;
        `CHK(n_rd, 3)
        `CHK(sdo_oe, 1'b0)
        n_rd = 0;
        ctl_host_i.open_f;
        put(8'h62);
        put(8'hFF);
        `CHK(r, `ID_BYTE)
        for (a = 7; a >= 6; a--)
        begin
            put(8'hFF);
            `CHK(r, 8'h3C ^ a[7:0])
            put(8'hFF);
            `CHK(r & 8'hFC, 8'hC0)
        end
        ctl_host_i.close_f;
        `CHK(n_rd, 3)
        $display("test read done");
    endtask
    task automatic t_abort;
        setce(8'h80);
        ctl_host_i.open_f;
        put(8'h83);
        put(8'h11);
        put(8'h22);
        ctl_host_i.close_f;
        expw(wv(`SPACE_LOCAL, 5'h03, 3'h0, 4'h8, 16'h0011));
        expw(wv(`SPACE_LOCAL, 5'h02, 3'h0, 4'h8, 16'h0022));
        `CHK(wq.size(), 0)
        frame2(8'hA0, 8'h77);
        expw(wv(`SPACE_GLOBAL, 5'h00, 3'h0, 4'h0, 16'h0077));
        ctl_host_i.open_f;
        put(8'hC1);
        put(8'h33);
        ctl_host_i.close_f;
        `CHK(wq.size(), 0)
        $display("test abort done");
    endtask
    task automatic t_power;
        int k;
        frame2(8'hB5, 8'h01);
        wq.delete();
        `CHK(suspend, 1'b1)
        `CHK(pll_sleep, 1'b1)
        ram(8'hE2, 16);
        `CHK(wq.size(), 0)
        frame2(8'hA0, 8'h66);
        expw(wv(`SPACE_GLOBAL, 5'h00, 3'h0, 4'h0, 16'h0066));
        setce(8'hF0);
        frame2(8'h88, 8'h00);
        setce(8'h20);
        frame2(8'h88, 8'h01);
        wq.delete();
        `CHK(chan_standby, 4'h2)
        `CHK(suspend, 1'b0)
        ram(8'hE2, 16);
        for (k = 0; k < 8; k++)
            expw(wv(`SPACE_COEF, 5'h02, 3'(7 - k), 4'h2,
                {4'(2 * k), 4'h7, 4'(2 * k + 1), 4'h4}));
        ram(8'hF1, 2);
        expw(wv(`SPACE_MSG, 5'h01, 3'h7, 4'h2, 16'h0717));
        `CHK(wq.size(), 0)
        $display("test power done");
    endtask
    initial
    begin
        reset = 1'b1;
        repeat (8) @(posedge core_clk);
        #1 reset = 1'b0;
        repeat (4) @(posedge core_clk);
        t_reset;
        t_bcast;
        t_read;
        t_abort;
        t_power;
        conclude;
    end
endmodule
bind codec_control_command_decoder codec_ctl_sva codec_ctl_sva_i (
    .core_clk, .reset, .cs_n_pin, .sdo_oe, .acc_wr_r, .acc_rd_r,
    .acc_space_r, .acc_mask_r, .acc_wdata_r, .channel_enable,
    .chan_standby, .pll_sleep, .suspend);
